// ===== common/txtim_defs.svh
// txtim_defs.svh: offsets, field positions, reset values and timing figures
// for the transmit delay, pulse length and no-response timers.
// assumes a 125 MHz system clock; all times are held in picoseconds.
`ifndef TXTIM_DEFS_SVH
`define TXTIM_DEFS_SVH

// register offsets
`define TXTIM_ADDR_PROTOCOL   8'h01
`define TXTIM_ADDR_TIMER_HIGH 8'h04
`define TXTIM_ADDR_TIMER_LOW  8'h05
`define TXTIM_ADDR_PULSE      8'h06
`define TXTIM_ADDR_WAIT       8'h07
`define TXTIM_ADDR_IRQ_STATUS 8'h0C
`define TXTIM_ADDR_IRQ_MASK   8'h0D
`define TXTIM_ADDR_STATE      8'h0E

// reset and preset values
`define TXTIM_PROTOCOL_RST    3'h7
`define TXTIM_TIMER_HIGH_RST  8'hC2
`define TXTIM_TIMER_LOW_RST   8'h00
`define TXTIM_PULSE_RST       8'h00
`define TXTIM_WAIT_RST        8'h0E
`define TXTIM_WAIT_VIC_HI     8'h14
`define TXTIM_WAIT_VIC_LO     8'h30
`define TXTIM_IRQ_MASK_RST    2'h0

// field positions
`define TXTIM_PROTO_MSB       2
`define TXTIM_START_SEL_MSB   7
`define TXTIM_START_SEL_LSB   6
`define TXTIM_LEN_HIGH_MSB    5
`define TXTIM_IRQ_NORESP      0
`define TXTIM_IRQ_LAUNCH      1

// protocol codes
`define TXTIM_PROTO_VIC_LO    3'h0
`define TXTIM_PROTO_VIC_HI    3'h1
`define TXTIM_PROTO_A106      3'h2
`define TXTIM_PROTO_A212      3'h3
`define TXTIM_PROTO_A424      3'h4

// start conditions
`define TXTIM_START_TX_SOF_BEG 2'h0
`define TXTIM_START_TX_SOF_END 2'h1
`define TXTIM_START_RX_SOF_BEG 2'h2

// direct command
`define TXTIM_CMD_FIFO_RESET  8'h0F

// timing
`define TXTIM_CLK_PS          8000
`define TXTIM_DELAY_STEP_PS   590000
`define TXTIM_PULSE_STEP_PS   73700
`define TXTIM_WAIT_STEP_PS    37760000
`define TXTIM_PW_VIC_PS       9440000
`define TXTIM_PW_A106_PS      2360000
`define TXTIM_PW_A212_PS      1400000
`define TXTIM_PW_A424_PS      737000
`define TXTIM_CYC(ps) (((ps) + `TXTIM_CLK_PS - 1) / `TXTIM_CLK_PS)

`endif

// ===== common/txtim_pkg.sv
// txtim_pkg: types shared by the transmit timer block.
// assumes txtim_defs.svh supplies every number.
package txtim_pkg;

  typedef struct packed {
    logic tx_sof_begin;
    logic tx_sof_end;
    logic rx_sof_begin;
    logic rx_sof_end;
    logic tx_eof_end;
  } txtim_frame_type;

  typedef enum logic [1:0] {
    D_IDLE,
    D_ARMED,
    D_COUNT
  } txtim_delay_state_type;

  typedef enum logic {
    P_IDLE,
    P_ON
  } txtim_pulse_state_type;

  typedef enum logic {
    W_IDLE,
    W_RUN
  } txtim_wait_state_type;

endpackage

// ===== src/txtim_top.sv
// txtim_top: delayed transmission timer, modulation pulse length and
// no-response wait timer, with a byte-wide register port and one interrupt.
// assumes all inputs synchronous to sys_clk; frame events are 1-cycle pulses.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "txtim_defs.svh"

// step tick: one-cycle pulse every step_ps on average, phase restarted by
// clear so that the first tick comes one full step after clear drops
module txtim_tick #(
  parameter int unsigned STEP_PS = 590000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clear,
  output logic      tick
);
  localparam logic [31:0] STEP = 32'(STEP_PS);
  localparam logic [31:0] CLKP = 32'(`TXTIM_CLK_PS);

  logic [31:0] acc;
  logic [31:0] next_acc;

  assign next_acc = acc + CLKP;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc  <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (clear) begin
      acc  <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (next_acc >= STEP) begin
      acc  <= next_acc - STEP;
      tick <= 1'b1;
    end else begin
      acc  <= next_acc;
      tick <= 1'b0;
    end
  end
endmodule

module txtim_top (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // device enable, low holds all presets
  input  wire logic                      enable,
  // register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // direct command strobe
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_code,
  // frame events and requests
  input  wire txtim_pkg::txtim_frame_type frame,
  input  wire logic                      tx_complete,
  input  wire logic                      tx_request,
  input  wire logic                      mod_request,
  // outputs
  output logic                           tx_launch,
  output logic                           mod_pulse,
  output logic                           irq
);

  logic [2:0]  protocol;
  logic [7:0]  timer_high;
  logic [7:0]  timer_low;
  logic [7:0]  pulse_override;
  logic [7:0]  wait_time;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        txc_seen;
  logic        suppress;

  logic        wr_proto;
  logic        preset;
  logic [13:0] delay_len;
  logic [1:0]  start_sel;
  logic        start_hit;
  logic        is_vicinity;
  logic [11:0] pulse_default;
  logic        noresp_evt;
  logic        launch_evt;

  logic        delay_tick;
  logic        pulse_tick;
  logic        wait_tick;
  logic [13:0] dcnt;
  logic [11:0] pcnt;
  logic [7:0]  wcnt;

  txtim_pkg::txtim_delay_state_type dstate;
  txtim_pkg::txtim_pulse_state_type pstate;
  txtim_pkg::txtim_wait_state_type  wstate;

  function automatic logic [7:0] wait_preset(input logic [2:0] p);
    if (p == `TXTIM_PROTO_VIC_HI)
      wait_preset = `TXTIM_WAIT_VIC_HI;
    else if (p == `TXTIM_PROTO_VIC_LO)
      wait_preset = `TXTIM_WAIT_VIC_LO;
    else
      wait_preset = `TXTIM_WAIT_RST;
  endfunction

  assign wr_proto   = reg_wr && (reg_addr == `TXTIM_ADDR_PROTOCOL);
  assign preset     = !enable || wr_proto;
  assign delay_len  = {timer_high[`TXTIM_LEN_HIGH_MSB:0], timer_low};
  assign start_sel  = timer_high[`TXTIM_START_SEL_MSB:`TXTIM_START_SEL_LSB];
  assign is_vicinity = (protocol == `TXTIM_PROTO_VIC_LO) ||
                       (protocol == `TXTIM_PROTO_VIC_HI);

  // default pulse width in clock cycles for the selected protocol
  always_comb begin
    if (is_vicinity)
      pulse_default = 12'(`TXTIM_CYC(`TXTIM_PW_VIC_PS));
    else if (protocol == `TXTIM_PROTO_A212)
      pulse_default = 12'(`TXTIM_CYC(`TXTIM_PW_A212_PS));
    else if (protocol == `TXTIM_PROTO_A424)
      pulse_default = 12'(`TXTIM_CYC(`TXTIM_PW_A424_PS));
    else
      pulse_default = 12'(`TXTIM_CYC(`TXTIM_PW_A106_PS));
  end

  // selected start condition of the delay timer
  always_comb begin
    if (start_sel == `TXTIM_START_TX_SOF_BEG)
      start_hit = frame.tx_sof_begin;
    else if (start_sel == `TXTIM_START_TX_SOF_END)
      start_hit = frame.tx_sof_end;
    else if (start_sel == `TXTIM_START_RX_SOF_BEG)
      start_hit = frame.rx_sof_begin;
    else
      start_hit = frame.rx_sof_end;
  end

  // protocol select register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protocol <= `TXTIM_PROTOCOL_RST;
    end else if (!enable) begin
      protocol <= `TXTIM_PROTOCOL_RST;
    end else if (wr_proto) begin
      protocol <= reg_wdata[`TXTIM_PROTO_MSB:0];
    end
  end

  // timer registers, preset on enable low and on protocol write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_high <= `TXTIM_TIMER_HIGH_RST;
      timer_low  <= `TXTIM_TIMER_LOW_RST;
    end else if (preset) begin
      timer_high <= `TXTIM_TIMER_HIGH_RST;
      timer_low  <= `TXTIM_TIMER_LOW_RST;
    end else if (reg_wr && reg_addr == `TXTIM_ADDR_TIMER_HIGH) begin
      timer_high <= reg_wdata;
    end else if (reg_wr && reg_addr == `TXTIM_ADDR_TIMER_LOW) begin
      timer_low <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_override <= `TXTIM_PULSE_RST;
    end else if (preset) begin
      pulse_override <= `TXTIM_PULSE_RST;
    end else if (reg_wr && reg_addr == `TXTIM_ADDR_PULSE) begin
      pulse_override <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_time <= `TXTIM_WAIT_RST;
    end else if (!enable) begin
      wait_time <= `TXTIM_WAIT_RST;
    end else if (wr_proto) begin
      wait_time <= wait_preset(reg_wdata[`TXTIM_PROTO_MSB:0]);
    end else if (reg_wr && reg_addr == `TXTIM_ADDR_WAIT) begin
      wait_time <= reg_wdata;
    end
  end

  // delayed transmission timer
  txtim_tick #(.STEP_PS(`TXTIM_DELAY_STEP_PS)) u_delay_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (dstate != txtim_pkg::D_COUNT),
    .tick    (delay_tick)
  );

  assign launch_evt = tx_launch;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dstate    <= txtim_pkg::D_IDLE;
      dcnt      <= 14'h0000;
      tx_launch <= 1'b0;
    end else if (preset) begin
      dstate    <= txtim_pkg::D_IDLE;
      dcnt      <= 14'h0000;
      tx_launch <= 1'b0;
    end else begin
      tx_launch <= 1'b0;
      case (dstate)
        txtim_pkg::D_IDLE: begin
          if (tx_request && delay_len == 14'h0000) begin
            tx_launch <= 1'b1;
          end else if (tx_request) begin
            dstate <= txtim_pkg::D_ARMED;
          end
        end
        txtim_pkg::D_ARMED: begin
          if (start_hit) begin
            dstate <= txtim_pkg::D_COUNT;
            dcnt   <= 14'h0000;
          end
        end
        txtim_pkg::D_COUNT: begin
          if (delay_tick && dcnt + 14'h0001 == delay_len) begin
            tx_launch <= 1'b1;
            dstate    <= txtim_pkg::D_IDLE;
          end else if (delay_tick) begin
            dcnt <= dcnt + 14'h0001;
          end
        end
        default: begin
          dstate <= txtim_pkg::D_IDLE;
        end
      endcase
    end
  end

  // modulation pulse generator
  txtim_tick #(.STEP_PS(`TXTIM_PULSE_STEP_PS)) u_pulse_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (pstate != txtim_pkg::P_ON),
    .tick    (pulse_tick)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate    <= txtim_pkg::P_IDLE;
      pcnt      <= 12'h000;
      mod_pulse <= 1'b0;
    end else if (!enable) begin
      pstate    <= txtim_pkg::P_IDLE;
      pcnt      <= 12'h000;
      mod_pulse <= 1'b0;
    end else begin
      case (pstate)
        txtim_pkg::P_IDLE: begin
          if (mod_request) begin
            pstate    <= txtim_pkg::P_ON;
            pcnt      <= 12'h000;
            mod_pulse <= 1'b1;
          end
        end
        txtim_pkg::P_ON: begin
          if (pulse_override != 8'h00) begin
            if (pulse_tick && pcnt + 12'h001 == {4'h0, pulse_override}) begin
              pstate    <= txtim_pkg::P_IDLE;
              mod_pulse <= 1'b0;
            end else if (pulse_tick) begin
              pcnt <= pcnt + 12'h001;
            end
          end else if (pcnt + 12'h001 >= pulse_default) begin
            pstate    <= txtim_pkg::P_IDLE;
            mod_pulse <= 1'b0;
          end else begin
            pcnt <= pcnt + 12'h001;
          end
        end
        default: begin
          pstate <= txtim_pkg::P_IDLE;
        end
      endcase
    end
  end

  // suppression by fifo reset after transmit complete
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_seen <= 1'b0;
      suppress <= 1'b0;
    end else if (preset || tx_request) begin
      txc_seen <= 1'b0;
      suppress <= 1'b0;
    end else begin
      if (tx_complete) begin
        txc_seen <= 1'b1;
      end
      if (cmd_valid && cmd_code == `TXTIM_CMD_FIFO_RESET && txc_seen) begin
        suppress <= 1'b1;
      end
    end
  end

  // no-response wait timer
  txtim_tick #(.STEP_PS(`TXTIM_WAIT_STEP_PS)) u_wait_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (wstate != txtim_pkg::W_RUN),
    .tick    (wait_tick)
  );

  assign noresp_evt = (wstate == txtim_pkg::W_RUN) && wait_tick &&
                      !frame.rx_sof_begin && !suppress &&
                      (wcnt + 8'h01 == wait_time);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wstate <= txtim_pkg::W_IDLE;
      wcnt   <= 8'h00;
    end else if (preset) begin
      wstate <= txtim_pkg::W_IDLE;
      wcnt   <= 8'h00;
    end else begin
      case (wstate)
        txtim_pkg::W_IDLE: begin
          if (frame.tx_eof_end && is_vicinity && !suppress &&
              wait_time != 8'h00) begin
            wstate <= txtim_pkg::W_RUN;
            wcnt   <= 8'h00;
          end
        end
        txtim_pkg::W_RUN: begin
          if (frame.rx_sof_begin || suppress || noresp_evt) begin
            wstate <= txtim_pkg::W_IDLE;
          end else if (wait_tick) begin
            wcnt <= wcnt + 8'h01;
          end
        end
        default: begin
          wstate <= txtim_pkg::W_IDLE;
        end
      endcase
    end
  end

  // interrupt status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status &
                     ~((reg_wr && reg_addr == `TXTIM_ADDR_IRQ_STATUS) ?
                       reg_wdata[1:0] : 2'h0)) |
                    {launch_evt, noresp_evt};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `TXTIM_IRQ_MASK_RST;
    end else if (reg_wr && reg_addr == `TXTIM_ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `TXTIM_ADDR_PROTOCOL) begin
      reg_rdata <= {5'h00, protocol};
    end else if (reg_addr == `TXTIM_ADDR_TIMER_HIGH) begin
      reg_rdata <= timer_high;
    end else if (reg_addr == `TXTIM_ADDR_TIMER_LOW) begin
      reg_rdata <= timer_low;
    end else if (reg_addr == `TXTIM_ADDR_PULSE) begin
      reg_rdata <= pulse_override;
    end else if (reg_addr == `TXTIM_ADDR_WAIT) begin
      reg_rdata <= wait_time;
    end else if (reg_addr == `TXTIM_ADDR_IRQ_STATUS) begin
      reg_rdata <= {6'h00, irq_status};
    end else if (reg_addr == `TXTIM_ADDR_IRQ_MASK) begin
      reg_rdata <= {6'h00, irq_mask};
    end else if (reg_addr == `TXTIM_ADDR_STATE) begin
      reg_rdata <= {3'h0, suppress, txc_seen, wstate == txtim_pkg::W_RUN,
                    pstate == txtim_pkg::P_ON,
                    dstate != txtim_pkg::D_IDLE};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ===== testbench/tb_tx_delay_pulse_noresp_timers.sv
// tb_tx_delay_pulse_noresp_timers: self-checking bench for txtim_top.
// assumes the bound checker and a tag model answering after tx eof.
`timescale 1ns/100ps
`include "txtim_defs.svh"
module tb_tx_delay_pulse_noresp_timers;
  logic                       sys_clk;
  logic                       rst_n;
  logic                       enable;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [7:0]                 reg_rdata;
  logic                       cmd_valid;
  logic [7:0]                 cmd_code;
  txtim_pkg::txtim_frame_type drv;
  txtim_pkg::txtim_frame_type frame;
  logic                       tag_sof;
  logic                       respond;
  logic                       tx_complete;
  logic                       tx_request;
  logic                       mod_request;
  logic                       tx_launch;
  logic                       mod_pulse;
  logic                       irq;
  logic                       rd_d = 1'b0;
  logic [31:0]                rnd;
  logic [7:0]                 exp_q[$];
  int                         err_total;
  int                         n_compared;
  int                         n;
  int                         e;
  always_comb begin
    frame = drv;
    frame.rx_sof_begin = tag_sof;
  end
  txtim_top txtim_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .enable(enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .frame(frame), .tx_complete(tx_complete), .tx_request(tx_request),
    .mod_request(mod_request), .tx_launch(tx_launch),
    .mod_pulse(mod_pulse), .irq(irq));
  txtim_tag_model txtim_tag_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .tx_eof_end(frame.tx_eof_end),
    .respond(respond), .resp_delay(16'h0032), .rx_sof_begin(tag_sof));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic in_range(input string what, input int lo, input int hi);
    check(what, n[15:0], (n >= lo && n <= hi) ? n[15:0] : lo[15:0]);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read data stands in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1) begin
      check("reg_rdata", {8'h00, reg_rdata},
            {8'h00, exp_q.pop_front()});
    end
    rd_d <= reg_rd;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    exp_q.push_back(d);
    @(posedge sys_clk);
  endtask
  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pulse_len(input int lo, input int hi);
    mod_request <= 1'b1;
    @(posedge sys_clk);
    mod_request <= 1'b0;
    n = 0;
    repeat (1500) begin
      @(negedge sys_clk);
      if (mod_pulse === 1'b1) n++;
    end
    in_range("mod_pulse width", lo, hi);
    @(posedge sys_clk);
  endtask
  task automatic wait_for(input string what, input bit use_irq,
                          input int lo, input int hi);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (n < 6000 && (use_irq ? irq : tx_launch) !== 1'b1);
    in_range(what, lo, hi);
    @(posedge sys_clk);
  endtask
  task automatic eof(input logic r);
    respond <= r;
    drv.tx_eof_end <= 1'b1;
    @(posedge sys_clk);
    drv.tx_eof_end <= 1'b0;
  endtask
  task automatic quiet(input string what);
    n = 0;
    repeat (5000) begin
      @(negedge sys_clk);
      if (irq === 1'b1) n++;
    end
    check(what, n[15:0], 16'h0000);
    @(posedge sys_clk);
  endtask
  initial begin
    err_total = 0;
    n_compared = 0;
    rst_n = 1'b0;
    enable = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {cmd_valid, cmd_code, tx_complete, tx_request, mod_request} = '0;
    drv = '0;
    respond = 1'b0;
    rnd = 32'h744c6998;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h04, 8'hC2);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h0E);
    rd(8'h3F, 8'h00);
    // random contents, then a protocol write presets them
    for (int p = 0; p < 3; p++) begin
      rnd = lfsr(rnd);
      wr(8'h05, rnd[7:0]);
      wr(8'h06, rnd[15:8]);
      wr(8'h07, rnd[23:16]);
      rd(8'h05, rnd[7:0]);
      wr(8'h01, 8'(p));
      for (int i = 0; i < 3; i++) begin
        e = 5 + (i + p) % 3;
        rd(8'(e), e != 7 ? 8'h00 : p == 0 ? `TXTIM_WAIT_VIC_LO :
           p == 1 ? `TXTIM_WAIT_VIC_HI : `TXTIM_WAIT_RST);
      end
    end
    wr(8'h05, 8'h5A);
    wr(8'h07, 8'hA5);
    idle();
    enable <= 1'b0;
    @(posedge sys_clk);
    enable <= 1'b1;
    rd(8'h07, 8'h0E);
    rd(8'h05, 8'h00);
    for (int p = 0; p < 5; p++) begin
      wr(8'h01, 8'(p));
      idle();
      e = p < 2 ? `TXTIM_PW_VIC_PS : p == 2 ? `TXTIM_PW_A106_PS :
          p == 3 ? `TXTIM_PW_A212_PS : `TXTIM_PW_A424_PS;
      e = (e + `TXTIM_CLK_PS - 1) / `TXTIM_CLK_PS;
      pulse_len(e, e);
    end
    wr(8'h06, 8'h03);
    idle();
    e = 3 * `TXTIM_PULSE_STEP_PS / `TXTIM_CLK_PS;
    pulse_len(e, e + 2);
    // delayed launch two steps after the end of tx sof
    wr(8'h01, 8'h02);
    wr(8'h04, 8'h40);
    wr(8'h05, 8'h02);
    wr(8'h0D, 8'h02);
    idle();
    tx_request <= 1'b1;
    @(posedge sys_clk);
    tx_request <= 1'b0;
    quiet("launch before start event");
    drv.tx_sof_end <= 1'b1;
    @(posedge sys_clk);
    drv.tx_sof_end <= 1'b0;
    e = 2 * `TXTIM_DELAY_STEP_PS / `TXTIM_CLK_PS;
    wait_for("delayed launch", 1'b0, e, e + 6);
    wait_for("launch irq", 1'b1, 1, 3);
    rd(8'h0C, 8'h02);
    wr(8'h0C, 8'h02);
    wr(8'h05, 8'h00);
    idle();
    @(negedge sys_clk);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    @(posedge sys_clk);
    tx_request <= 1'b1;
    @(posedge sys_clk);
    tx_request <= 1'b0;
    wait_for("zero count launch", 1'b0, 1, 2);
    // no-response wait of one step on the vicinity protocol
    wr(8'h01, 8'h01);
    wr(8'h07, 8'h01);
    wr(8'h0C, 8'h03);
    wr(8'h0D, 8'h01);
    idle();
    eof(1'b0);
    e = `TXTIM_WAIT_STEP_PS / `TXTIM_CLK_PS;
    wait_for("no response irq", 1'b1, e, e + 6);
    rd(8'h0C, 8'h01);
    wr(8'h0C, 8'h01);
    idle();
    eof(1'b1);
    quiet("irq despite tag answer");
    tx_complete <= 1'b1;
    @(posedge sys_clk);
    tx_complete <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_code <= `TXTIM_CMD_FIFO_RESET;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    eof(1'b0);
    quiet("irq after fifo reset");
    wr(8'h01, 8'h02);
    wr(8'h07, 8'h01);
    idle();
    eof(1'b0);
    quiet("irq on proximity protocol");
    conclude();
  end
endmodule

// ===== testbench/txtim_tag_model.sv
// txtim_tag_model: a tag in the field that answers a reader frame.
// assumes tx_eof_end is a one-cycle pulse on sys_clk.
`timescale 1ns/100ps
module txtim_tag_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // reader side
  input  wire logic        tx_eof_end,
  // behaviour chosen by the bench
  input  wire logic        respond,
  input  wire logic [15:0] resp_delay,
  // start of the tag answer
  output logic             rx_sof_begin
);
  logic [15:0] cnt;
  logic        busy;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt          <= 16'h0000;
      busy         <= 1'b0;
      rx_sof_begin <= 1'b0;
    end else begin
      rx_sof_begin <= busy && cnt == 16'h0000;
      if (tx_eof_end && respond) begin
        busy <= 1'b1;
        cnt  <= resp_delay;
      end else if (busy && cnt == 16'h0000) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule

// ===== testbench/txtim_top_assertions.sv
// txtim_top_assertions.sv: concurrent checks bound into txtim_top.
// assumes only the register port, requests and outputs of txtim_top.
`timescale 1ns/100ps
module txtim_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // register port
  input wire logic       enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests and outputs
  input wire logic       mod_request,
  input wire logic       tx_request,
  input wire logic       mod_pulse,
  input wire logic       tx_launch
);
  logic [2:0]  proto;
  logic [7:0]  ovr;
  logic [13:0] len;
  logic [11:0] plen;
  logic [11:0] pexp;
  logic        pset;
  assign pset = reg_wr && reg_addr == 8'h01;
  // shadow of protocol, override and delay count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      proto <= 3'h7;
      ovr   <= 8'h00;
      len   <= 14'h0200;
    end else if (!enable || pset) begin
      proto <= enable ? reg_wdata[2:0] : 3'h7;
      ovr   <= 8'h00;
      len   <= 14'h0200;
    end else if (reg_wr && reg_addr == 8'h04) begin
      len[13:8] <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == 8'h05) begin
      len[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h06) begin
      ovr <= reg_wdata;
    end
  end
  // cycles the pulse has been high so far
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) plen <= 12'h000;
    else plen <= mod_pulse ? plen + 12'h001 : 12'h000;
  end
  always_comb begin
    case (proto)
      3'h0, 3'h1: pexp = 12'h49C;
      3'h3: pexp = 12'h0AF;
      3'h4: pexp = 12'h05D;
      default: pexp = 12'h127;
    endcase
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  low_preset_a: assert property (
    pset ##1 (reg_rd && reg_addr == 8'h05) |=> reg_rdata == 8'h00)
    else $error("low delay byte kept after protocol write");
  pulse_preset_a: assert property (
    pset ##1 (reg_rd && reg_addr == 8'h06) |=> reg_rdata == 8'h00)
    else $error("pulse override kept after protocol write");
  wait_preset_a: assert property (
    (pset && reg_wdata[2:0] > 3'h1) ##1 (reg_rd && reg_addr == 8'h07)
    |=> reg_rdata == 8'h0E) else $error("wait not preset for protocol");
  enable_preset_a: assert property (
    !enable ##1 (reg_rd && reg_addr == 8'h07) |=> reg_rdata == 8'h0E)
    else $error("wait not preset while disabled");
  pulse_width_a: assert property (
    $fell(mod_pulse) && ovr == 8'h00 |-> plen == pexp)
    else $error("default pulse width wrong");
  pulse_start_a: assert property (
    enable && mod_request && !mod_pulse |=> mod_pulse)
    else $error("pulse not started");
  launch_single_a: assert property (
    tx_launch |=> !tx_launch) else $error("launch longer than one cycle");
  zero_launch_a: assert property (
    enable && tx_request && len == 14'h0000 |=> tx_launch)
    else $error("zero count did not launch at once");
endmodule

bind txtim_top txtim_checker txtim_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .enable(enable),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_request(mod_request),
  .tx_request(tx_request), .mod_pulse(mod_pulse), .tx_launch(tx_launch));
